/* File: testbench/gtmr_ext_source.sv */
`timescale 1ns/100ps
module gtmr_ext_source
(
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] nPulse,
   input wire logic ampOut,
   input wire logic ampOe,
   output logic pin,
   output logic busy,
   output logic crystalIn
);
   initial
   begin
      pin = 1'b0;
      busy = 1'b0;
      crystalIn = 1'b0;
   end
   // Three clocks each side, above the one-clock minimum the sampler needs
   always @(posedge clk)
   begin
      if (go && !busy)
      begin
         busy <= 1'b1;
         repeat (nPulse)
         begin
            repeat (3) @(posedge clk);
            pin <= 1'b1;
            repeat (3) @(posedge clk);
            pin <= 1'b0;
         end
         busy <= 1'b0;
      end
   end
   // Crystal closes the amplifier loop one clock late; still while disabled
   always @(posedge clk)
      crystalIn <= ampOe & ampOut;
endmodule

/* File: testbench/gtmr_timer_bench.sv */
`timescale 1ns/100ps
module gtmr_timer_bench;
   import gtmr_pkg::*;
   logic clk;
   logic sys_rst;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   logic extPin;
   logic crystalIn;
   logic ampOut;
   logic ampOe;
   logic gateSignal;
   logic [2:0] gateAltIn;
   logic sleepIn;
   logic irq;
   logic go;
   logic [7:0] nPulse;
   logic busy;
   int nMismatch;
   int checks;
   // Internal divide used here; internal-clock spans must be multiples of it
   localparam int BENCH_DIV = 2;

   gtmr_timer #(.INT_DIV(BENCH_DIV)) dut
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .timerClockPin(extPin),
      .crystalInputPin(crystalIn),
      .crystalAmpOutputPin(ampOut),
      .crystalAmpOutputOe(ampOe),
      .gateSignal(gateSignal),
      .gateAltIn(gateAltIn),
      .sleepIn(sleepIn),
      .irq(irq)
   );

   gtmr_ext_source src
   (
      .clk(clk),
      .go(go),
      .nPulse(nPulse),
      .ampOut(ampOut),
      .ampOe(ampOe),
      .pin(extPin),
      .busy(busy),
      .crystalIn(crystalIn)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h000000, a};
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(a, 1'b1, {24'h000000, d}, r);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
      logic [31:0] r;
      bus(a, 1'b0, 32'h00000000, r);
      check(r, {24'h000000, e}, what);
      check({31'h0, hresp}, 32'h0, "response okay");
   endtask

   task automatic cnt(input logic [15:0] e);
      rchk(OFS_CNTL, e[7:0], "count low");
      rchk(OFS_CNTH, e[15:8], "count high");
   endtask

   task automatic setCount(input logic [15:0] v);
      wr(OFS_CTRL, 8'h00);
      wr(OFS_CNTL, v[7:0]);
      wr(OFS_CNTH, v[15:8]);
   endtask

   // Waits out the three-clock edge sync after the last pulse
   task automatic pulses(input int n);
      nPulse <= 8'(n);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      do @(posedge clk); while (busy);
      repeat (8) @(posedge clk);
   endtask

   task automatic done(input string name);
      $display("test %s done", name);
   endtask

   function automatic logic [15:0] expPs(input int k, input int p);
      return 16'(k >> p);
   endfunction

   function automatic logic [15:0] expGate(input int k, input logic lvl, input logic pol);
      return (lvl === pol) ? 16'(k) : 16'h0000;
   endfunction

   initial
   begin
      repeat (40000) @(posedge clk);
      nMismatch++;
      $display("MISMATCH %0t watchdog expired", $time);
      complete_run();
   end

   initial
   begin : main
      int k;
      logic lvl;
      logic [1:0] s;
      logic pol;
      logic [31:0] v;
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      gateSignal = 1'b0;
      gateAltIn = 3'h0;
      sleepIn = 1'b0;
      go = 1'b0;
      nPulse = 8'h00;
      nMismatch = 0;
      checks = 0;
      void'($urandom(46));
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      wr(8'h18, 8'hFF);
      for (int i = 0; i < 7; i++)
         rchk(8'(i * 4), 8'h00, "reset or unmapped");
      done("reset");
      v = $urandom;
      setCount(v[15:0]);
      cnt(v[15:0]);
      done("count access");
      // Odd wait plus three bus cycles gives an even span, so the tick phase cannot matter
      k = 2 * $urandom_range(10, 30) + 1;
      setCount(16'h0000);
      wr(OFS_CTRL, 8'h01);
      repeat (k) @(posedge clk);
      wr(OFS_CTRL, 8'h00);
      cnt(16'((k + 3) / BENCH_DIV));
      done("internal clock");
      for (int p = 0; p < 4; p++)
      begin
         k = $urandom_range(6, 20);
         setCount(16'h0000);
         wr(OFS_CTRL, 8'h05 | 8'(p << 4));
         pulses(k);
         cnt(expPs(k, p));
      end
      done("prescale");
      for (int i = 0; i < 8; i++)
      begin
         s = 2'(i);
         pol = i[2];
         lvl = 1'($urandom);
         gateSignal <= (s == 2'h0) ? lvl : ~lvl;
         for (int j = 0; j < 3; j++)
            gateAltIn[j] <= (s == 2'(j + 1)) ? lvl : ~lvl;
         wr(OFS_GATE, {1'b1, pol, 4'h0, s});
         rchk(OFS_GATE, {1'b1, pol, 4'h0, s}, "gate control");
         setCount(16'h0000);
         wr(OFS_CTRL, 8'h05);
         pulses(4);
         cnt(expGate(4, lvl, pol));
      end
      wr(OFS_GATE, 8'h00);
      done("gate");
      sleepIn <= 1'b1;
      setCount(16'h0000);
      wr(OFS_CTRL, 8'h07);
      pulses(5);
      cnt(16'h0005);
      setCount(16'h0000);
      wr(OFS_CTRL, 8'h05);
      pulses(5);
      cnt(16'h0000);
      sleepIn <= 1'b0;
      done("sleep");
      setCount(16'hFFFE);
      wr(OFS_MASK, 8'h01);
      wr(OFS_CTRL, 8'h05);
      pulses(2);
      cnt(16'h0000);
      rchk(OFS_STAT, 8'h01, "overflow flag");
      check({31'h0, irq}, 32'h1, "irq raised");
      wr(OFS_MASK, 8'h00);
      repeat (3) @(posedge clk);
      check({31'h0, irq}, 32'h0, "irq masked");
      wr(OFS_STAT, 8'h01);
      rchk(OFS_STAT, 8'h00, "flag cleared");
      done("overflow");
      // Oscillator settle wait: preset, then overflow after 1024 crystal cycles
      setCount(16'hFC00);
      wr(OFS_STAT, 8'h01);
      wr(OFS_MASK, 8'h01);
      sleepIn <= 1'b1;
      wr(OFS_CTRL, 8'h0F);
      repeat (3) @(posedge clk);
      check({31'h0, ampOe}, 32'h1, "amplifier enabled");
      k = 0;
      while (irq !== 1'b1 && k < 8000)
      begin
         @(posedge clk);
         k++;
      end
      check({31'h0, irq}, 32'h1, "crystal overflow");
      sleepIn <= 1'b0;
      rchk(OFS_CNTH, 8'h00, "count wrapped");
      done("crystal");
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      rchk(OFS_CTRL, 8'h00, "ctrl after reset");
      rchk(OFS_MASK, 8'h00, "mask after reset");
      cnt(16'h0000);
      done("second reset");
      complete_run();
   end
endmodule

/* File: verilog/gtmr_edge_sync.sv */
`timescale 1ns/100ps
module gtmr_edge_sync
   import gtmr_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pinIn,
   input wire logic bypassSync,
   output logic risePulse
);

   logic syncA_reg;
   logic syncB_reg;
   logic syncPrev_reg;
   logic raw_reg;
   logic rawPrev_reg;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         syncA_reg <= 1'b0;
         syncB_reg <= 1'b0;
         syncPrev_reg <= 1'b0;
      end
      else
      begin
         syncA_reg <= pinIn;
         syncB_reg <= syncA_reg;
         syncPrev_reg <= syncB_reg;
      end
   end

   // Short path, no resynchronisation
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         raw_reg <= 1'b0;
         rawPrev_reg <= 1'b0;
      end
      else
      begin
         raw_reg <= pinIn;
         rawPrev_reg <= raw_reg;
      end
   end

   // Paths differ in depth, so a mode switch can drop or repeat an edge
   assign risePulse = bypassSync ? (raw_reg & ~rawPrev_reg) : (syncB_reg & ~syncPrev_reg);

endmodule

/* File: verilog/gtmr_pkg.sv */
package gtmr_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_GATE = 8'h04;
   localparam logic [7:0] OFS_CNTL = 8'h08;
   localparam logic [7:0] OFS_CNTH = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;

   // timer_control_reg fields
   localparam int CTRL_ON = 0;
   localparam int CTRL_NSYNC = 1;
   localparam int CTRL_CLKSEL = 2;
   localparam int CTRL_OSCEN = 3;
   localparam int CTRL_PS_LO = 4;
   localparam int CTRL_PS_HI = 5;

   // gate_control_reg fields
   localparam int GATE_SRC_LO = 0;
   localparam int GATE_SRC_HI = 1;
   localparam int GATE_POL = 6;
   localparam int GATE_EN = 7;

   localparam int STAT_OVF = 0;

   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] GATE_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;

   // Internal timer clock is the system clock divided by this
   localparam int INT_CLK_DIV = 4;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   typedef enum logic [0:0]
   {
      CLK_INTERNAL = 1'b0,
      CLK_EXTERNAL = 1'b1
   } gtmr_clksrc_type;

   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b00,
      BUS_WRITE = 2'b01,
      BUS_READ1 = 2'b10,
      BUS_READ2 = 2'b11
   } gtmr_bus_type;

   // Terminal prescale count for 1, 2, 4 or 8
   function automatic logic [2:0] prescale_limit(input logic [1:0] sel);
      case (sel)
         2'b00: prescale_limit = 3'h0;
         2'b01: prescale_limit = 3'h1;
         2'b10: prescale_limit = 3'h3;
         default: prescale_limit = 3'h7;
      endcase
   endfunction

endpackage

/* File: verilog/gtmr_timer.sv */
`timescale 1ns/100ps
module gtmr_timer
   import gtmr_pkg::*;
#(
   parameter int INT_DIV = INT_CLK_DIV
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic timerClockPin,
   input wire logic crystalInputPin,
   output logic crystalAmpOutputPin,
   output logic crystalAmpOutputOe,
   input wire logic gateSignal,
   input wire logic [2:0] gateAltIn,
   input wire logic sleepIn,
   output logic irq
);

   gtmr_bus_type busState_reg;
   logic [7:0] busAddr_reg;
   logic [7:0] timerControl_reg;
   logic [7:0] gateControl_reg;
   logic [7:0] status_reg;
   logic [7:0] mask_reg;
   logic [15:0] count_reg;
   logic [2:0] prescale_reg;
   logic [7:0] intDiv_reg;
   logic hreadyout_reg;
   logic [31:0] hrdata_reg;
   logic crystalAmp_reg;
   logic crystalOe_reg;
   logic irq_reg;

   logic accept;
   logic wrCtrl, wrGate, wrCntL, wrCntH, wrCount, wrStat, wrMask;
   logic timerOn, syncDisable, oscEnable;
   gtmr_clksrc_type clkSel;
   logic [1:0] prescaleSelect;
   logic gateEnable, gatePolarity, gateLevel, gateOk;
   logic extPin, extRise, intTick, srcAllowed, srcTick;
   logic prescaleStep, incTick, overflowEvent;
   logic [7:0] status_next;
   logic [31:0] readMux;

   assign hreadyout = hreadyout_reg;
   assign hrdata = hrdata_reg;
   assign hresp = 1'b0;
   assign crystalAmpOutputPin = crystalAmp_reg;
   assign crystalAmpOutputOe = crystalOe_reg;
   assign irq = irq_reg;

   assign timerOn = timerControl_reg[CTRL_ON];
   assign syncDisable = timerControl_reg[CTRL_NSYNC];
   assign oscEnable = timerControl_reg[CTRL_OSCEN];
   assign clkSel = gtmr_clksrc_type'(timerControl_reg[CTRL_CLKSEL]);
   assign prescaleSelect = timerControl_reg[CTRL_PS_HI:CTRL_PS_LO];
   assign gateEnable = gateControl_reg[GATE_EN];
   assign gatePolarity = gateControl_reg[GATE_POL];

   // Bus interface: writes complete with no wait, reads take one wait state
   assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign wrCtrl = (busState_reg == BUS_WRITE) && (busAddr_reg == OFS_CTRL);
   assign wrGate = (busState_reg == BUS_WRITE) && (busAddr_reg == OFS_GATE);
   assign wrCntL = (busState_reg == BUS_WRITE) && (busAddr_reg == OFS_CNTL);
   assign wrCntH = (busState_reg == BUS_WRITE) && (busAddr_reg == OFS_CNTH);
   assign wrStat = (busState_reg == BUS_WRITE) && (busAddr_reg == OFS_STAT);
   assign wrMask = (busState_reg == BUS_WRITE) && (busAddr_reg == OFS_MASK);
   assign wrCount = wrCntL || wrCntH;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         busState_reg <= BUS_IDLE;
         busAddr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
      end
      else
      begin
         case (busState_reg)
            BUS_READ1:
            begin
               busState_reg <= BUS_READ2;
               hreadyout_reg <= 1'b1;
            end
            default:
            begin
               if (accept)
               begin
                  busAddr_reg <= haddr[7:0];
                  busState_reg <= hwrite ? BUS_WRITE : BUS_READ1;
                  hreadyout_reg <= hwrite;
               end
               else
               begin
                  busState_reg <= BUS_IDLE;
                  hreadyout_reg <= 1'b1;
               end
            end
         endcase
      end
   end

   // Count is in the system clock domain, so a byte read is never torn
   always_comb
   begin
      readMux = 32'h0000_0000;
      case (busAddr_reg)
         OFS_CTRL: readMux[7:0] = timerControl_reg;
         OFS_GATE: readMux[7:0] = gateControl_reg;
         OFS_CNTL: readMux[7:0] = count_reg[7:0];
         OFS_CNTH: readMux[7:0] = count_reg[15:8];
         OFS_STAT: readMux[7:0] = status_reg;
         OFS_MASK: readMux[7:0] = mask_reg;
         default: readMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         hrdata_reg <= 32'h0000_0000;
      end
      else if (busState_reg == BUS_READ1)
      begin
         hrdata_reg <= readMux;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         timerControl_reg <= CTRL_RST;
         gateControl_reg <= GATE_RST;
         mask_reg <= MASK_RST;
      end
      else
      begin
         if (wrCtrl)
         begin
            timerControl_reg <= hwdata[7:0];
         end
         if (wrGate)
         begin
            gateControl_reg <= {hwdata[7:6], 4'h0, hwdata[1:0]};
         end
         if (wrMask)
         begin
            mask_reg <= {7'h00, hwdata[STAT_OVF]};
         end
      end
   end

   // Crystal amplifier modelled as an inverter; sleep does not stop it
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         crystalAmp_reg <= 1'b0;
         crystalOe_reg <= 1'b0;
      end
      else
      begin
         crystalAmp_reg <= oscEnable & ~crystalInputPin;
         crystalOe_reg <= oscEnable;
      end
   end

   assign extPin = oscEnable ? crystalInputPin : timerClockPin;

   gtmr_edge_sync u_ext_edge
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(extPin),
      .bypassSync(syncDisable),
      .risePulse(extRise)
   );

   // Internal timer clock stops while the core sleeps
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         intDiv_reg <= 8'h00;
      end
      else if (!sleepIn)
      begin
         intDiv_reg <= (intDiv_reg == 8'(INT_DIV - 1)) ? 8'h00 : intDiv_reg + 8'h01;
      end
   end
   assign intTick = !sleepIn && (intDiv_reg == 8'h00);

   assign srcAllowed = !sleepIn || (syncDisable && (clkSel == CLK_EXTERNAL));
   assign srcTick = srcAllowed && ((clkSel == CLK_EXTERNAL) ? extRise : intTick);

   always_comb
   begin
      case (gateControl_reg[GATE_SRC_HI:GATE_SRC_LO])
         2'b00: gateLevel = gateSignal;
         2'b01: gateLevel = gateAltIn[0];
         2'b10: gateLevel = gateAltIn[1];
         default: gateLevel = gateAltIn[2];
      endcase
   end

   assign gateOk = !gateEnable || (gateLevel == gatePolarity);
   assign prescaleStep = timerOn && srcTick && gateOk;
   // At or above terminal, so lowering prescale_select mid-count cannot stall a full wrap
   assign incTick = prescaleStep && (prescale_reg >= prescale_limit(prescaleSelect));
   assign overflowEvent = incTick && !wrCount && (count_reg == COUNT_MAX);

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prescale_reg <= 3'h0;
      end
      else if (wrCount)
      begin
         prescale_reg <= 3'h0;
      end
      else if (incTick)
      begin
         prescale_reg <= 3'h0;
      end
      else if (prescaleStep)
      begin
         prescale_reg <= prescale_reg + 3'h1;
      end
   end

   // A byte write beats a coincident increment
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         count_reg <= COUNT_RST;
      end
      else if (wrCount)
      begin
         if (wrCntL)
         begin
            count_reg[7:0] <= hwdata[7:0];
         end
         if (wrCntH)
         begin
            count_reg[15:8] <= hwdata[7:0];
         end
      end
      else if (incTick)
      begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // Hardware set wins over a write-one clear in the same cycle
   always_comb
   begin
      status_next = status_reg;
      if (wrStat)
      begin
         status_next = status_reg & ~{7'h00, hwdata[STAT_OVF]};
      end
      if (overflowEvent)
      begin
         status_next[STAT_OVF] = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         status_reg <= STAT_RST;
         irq_reg <= 1'b0;
      end
      else
      begin
         status_reg <= status_next;
         irq_reg <= |(status_reg & mask_reg);
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   property p_prescale_div;
      (prescaleStep && !wrCount && (prescale_reg < prescale_limit(prescaleSelect)))
         |=> (prescale_reg == $past(prescale_reg) + 3'h1) && $stable(count_reg);
   endproperty
   a_prescale_div: assert property (p_prescale_div) else $error("prescaler did not step below terminal");
   property p_prescale_clear;
      wrCount |=> (prescale_reg == 3'h0);
   endproperty
   a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler not cleared on write");
   property p_osc_drive;
      (oscEnable && !wrCtrl) |=> crystalAmpOutputOe;
   endproperty
   a_osc_drive: assert property (p_osc_drive) else $error("oscillator not driven");
   property p_sleep_stop;
      (sleepIn && !(syncDisable && clkSel == CLK_EXTERNAL) && !wrCount) |=> $stable(count_reg);
   endproperty
   a_sleep_stop: assert property (p_sleep_stop) else $error("count moved in synced sleep");
   property p_gate_hold;
      (gateEnable && (gateLevel != gatePolarity) && !wrCount) |=> $stable(count_reg) && $stable(prescale_reg);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate inactive");
   property p_gate_count;
      (timerOn && srcTick && gateEnable && (gateLevel == gatePolarity) && prescaleSelect == 2'b00 && !wrCount)
         |=> (count_reg == $past(count_reg) + 16'h0001);
   endproperty
   a_gate_count: assert property (p_gate_count) else $error("count missed active gate edge");
   property p_rollover;
      (incTick && !wrCount && count_reg == COUNT_MAX) |=> (count_reg == 16'h0000) && status_reg[STAT_OVF];
   endproperty
   a_rollover: assert property (p_rollover) else $error("bad rollover");
   property p_read_low;
      (busState_reg == BUS_READ1 && busAddr_reg == OFS_CNTL) |=> hreadyout && (hrdata[7:0] == $past(count_reg[7:0]));
   endproperty
   a_read_low: assert property (p_read_low) else $error("count low read mismatch");
   property p_irq;
      (status_reg[STAT_OVF] && mask_reg[STAT_OVF]) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   c_overflow: cover property (overflowEvent);
   c_gate_hold: cover property (gateEnable && timerOn && srcTick && !gateOk);
   c_sleep_count: cover property (sleepIn && incTick);
   c_irq: cover property ($rose(irq));

endmodule
